// ===== rtl/tlsf_pkg.sv
package tlsf_pkg;
  localparam int AW = 8;
  localparam int NCH = 4;
  localparam logic [AW-1:0] ADDR_CTRL  = 8'h00;
  localparam logic [AW-1:0] ADDR_TERM  = 8'h04;
  localparam logic [AW-1:0] ADDR_CUSLO = 8'h08;
  localparam logic [AW-1:0] ADDR_CUSHI = 8'h0C;
  localparam logic [AW-1:0] ADDR_STAT  = 8'h10;
  localparam int CB_PAT = 0;
  localparam int CB_ONE = 9;
  localparam int CB_CUR = 10;
  localparam int CB_DBL = 12;
  localparam int TB_CLK = 0;
  localparam int TB_DATA = 8;
  localparam logic [12:0] CTRL_RST = 13'h0000;
  localparam logic [9:0] TERM_RST = 10'h000;
  localparam logic [11:0] CUST_RST = 12'h000;
  localparam logic [3:0] HALF12 = 4'h6;
  localparam logic [3:0] HALF14 = 4'h7;
  localparam logic [11:0] POS_OB = 12'hFFF;
  localparam logic [11:0] POS_TC = 12'h7FF;
  localparam logic [11:0] NEG_OB = 12'h000;
  localparam logic [11:0] NEG_TC = 12'h800;
  localparam logic [11:0] TOG_A = 12'hAAA;
  localparam logic [11:0] TOG_B = 12'h555;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [1:0] {ORD_BYTE = 2'h0, ORD_BIT = 2'h1, ORD_WORD = 2'h2} tlsf_order_t;
  typedef enum logic [2:0] {
    PAT_NORM = 3'h0, PAT_ZERO = 3'h1, PAT_ONE = 3'h2, PAT_TOG = 3'h3,
    PAT_CUST = 3'h4, PAT_SYNC = 3'h5, PAT_DESK = 3'h6
  } tlsf_pat_t;
  typedef struct packed {
    logic        oneLane;
    logic        ser14;
    logic        sdr;
    tlsf_order_t order;
    logic        lsbFirst;
    logic        outputCodingSel;
    tlsf_pat_t   pat;
  } tlsf_cfg_t;
endpackage

// ===== rtl/tlsf_lane_map.sv
module tlsf_lane_map
  import tlsf_pkg::*;
(
  input  wire logic [13:0] wordA,
  input  wire logic [13:0] wordB,
  input  wire tlsf_cfg_t   cfg,
  output logic      [13:0] seq0,
  output logic      [13:0] seq1
);
  logic [3:0] half;
  logic [3:0] len;

  always_comb
  begin
    half = cfg.ser14 ? HALF14 : HALF12;
    len = (cfg.oneLane || cfg.order == ORD_WORD) ? {half[2:0], 1'b0} : half;
    seq0 = '0;
    seq1 = '0;
    for (int k = 0; k < 14; k++)
    begin
      int p;
      int kh;
      p = cfg.lsbFirst ? k : int'(len) - 1 - k; // R12
      kh = (k >= int'(half)) ? k - int'(half) : k;
      if (k < int'(len))
      begin
        if (cfg.pat == PAT_DESK)
        begin
          seq0[k] = (k % 2) == 0; // R18
          seq1[k] = (k % 2) == 0;
        end
        else if (cfg.pat == PAT_SYNC)
        begin
          seq0[k] = cfg.oneLane ? (k < int'(half)) : (kh < (int'(half) + 1) / 2); // R22
          seq1[k] = kh < (int'(half) + 1) / 2;
        end
        else if (cfg.oneLane || cfg.order == ORD_WORD)
        begin
          seq0[k] = wordA[p]; // R9
          seq1[k] = wordB[p];
        end
        else if (cfg.order == ORD_BIT)
        begin
          seq0[k] = wordA[2*p]; // R8
          seq1[k] = wordA[2*p+1];
        end
        else
        begin
          seq0[k] = wordA[p]; // R7
          seq1[k] = wordA[int'(half)+p];
        end
      end
    end
    if (cfg.oneLane)
    begin
      seq1 = '0; // R24
    end
  end
endmodule

// ===== rtl/tlsf_axil_slave.sv
module tlsf_axil_slave
  import tlsf_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic [AW-1:0] s_axil_awaddr,
  input  wire logic          s_axil_awvalid,
  output logic               s_axil_awready,
  input  wire logic [31:0]   s_axil_wdata,
  input  wire logic [3:0]    s_axil_wstrb,
  input  wire logic          s_axil_wvalid,
  output logic               s_axil_wready,
  output logic [1:0]         s_axil_bresp,
  output logic               s_axil_bvalid,
  input  wire logic          s_axil_bready,
  input  wire logic [AW-1:0] s_axil_araddr,
  input  wire logic          s_axil_arvalid,
  output logic               s_axil_arready,
  output logic [31:0]        s_axil_rdata,
  output logic [1:0]         s_axil_rresp,
  output logic               s_axil_rvalid,
  input  wire logic          s_axil_rready,
  output logic               wrEn,
  output logic [AW-1:0]      wrAddr,
  output logic [31:0]        wrData,
  output logic [3:0]         wrStrb,
  input  wire logic          wrOk,
  output logic [AW-1:0]      rdAddr,
  input  wire logic [31:0]   rdData,
  input  wire logic          rdOk
);
  typedef struct packed {
    logic          awHave;
    logic          wHave;
    logic [AW-1:0] addr;
    logic [31:0]   data;
    logic [3:0]    strb;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
  } tlsf_axs_t;

  tlsf_axs_t q;
  tlsf_axs_t d;

  assign s_axil_awready = !q.awHave && !q.bvalid;
  assign s_axil_wready = !q.wHave && !q.bvalid;
  assign s_axil_arready = !q.rvalid;
  assign s_axil_bvalid = q.bvalid;
  assign s_axil_bresp = q.bresp;
  assign s_axil_rvalid = q.rvalid;
  assign s_axil_rdata = q.rdata;
  assign s_axil_rresp = q.rresp;
  assign wrEn = q.awHave && q.wHave && !q.bvalid;
  assign wrAddr = q.addr;
  assign wrData = q.data;
  assign wrStrb = q.strb;
  assign rdAddr = s_axil_araddr;

  always_comb
  begin
    d = q;
    if (s_axil_awvalid && s_axil_awready)
    begin
      d.awHave = 1'b1;
      d.addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_axil_wready)
    begin
      d.wHave = 1'b1;
      d.data = s_axil_wdata;
      d.strb = s_axil_wstrb;
    end
    if (wrEn)
    begin
      d.awHave = 1'b0;
      d.wHave = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = wrOk ? RESP_OK : RESP_ERR;
    end
    if (q.bvalid && s_axil_bready)
    begin
      d.bvalid = 1'b0;
    end
    if (s_axil_arvalid && s_axil_arready)
    begin
      d.rvalid = 1'b1;
      d.rdata = rdData;
      d.rresp = rdOk ? RESP_OK : RESP_ERR;
    end
    else if (q.rvalid && s_axil_rready)
    begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule

// ===== rtl/tlsf_formatter.sv
// Behaviour
// R1 - 12x two-lane: six bits per lane per sample
// R2 - DDR bit clock default, SDR optional; code ignores sdr in one-lane mode and always uses DDR there
// R3 - Byte-wise, bit-wise, word-wise lane orders selectable
// R4 - 14x pads two zeros above MSB
// R5 - 14x: seven bits per lane; SDR frame 1x
// R6 - 14x DDR frame: 1x byte/bit, half word-wise
// R7 - Byte-wise: low bits lane 0, high lane 1
// R8 - Bit-wise: even bits lane 0, odd lane 1
// R9 - Word-wise: alternate samples between the two lanes
// R10 - Word-wise frame half rate, rises at word
// R11 - MSB first after reset, LSB selectable
// R12 - LSB first reverses each lane's sequence
// R13 - Two's complement default, offset binary selectable
// R14 - Positive overrange gives positive full scale
// R15 - Negative overrange gives negative full scale
// R16 - Drive current setting plus doubling bit held
// R17 - Separate clock and data termination selects held
// R18 - Deskew pattern alternates one and zero
// R19 - Toggle pattern alternates complementary codes per sample
// R20 - Test patterns on all four channels together
// R21 - Custom 12-bit code from two registers
// R22 - Sync pattern: upper half ones, lower zeros
// R23 - Receiver shifts word boundary to match sync
// R24 - One-lane: whole word per lane, MSB first
// R25 - Test pattern replaces sample data when selected
module tlsf_formatter
  import tlsf_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                bitClkPin,
  input  wire logic [NCH-1:0][11:0] chanCode,
  input  wire logic [NCH-1:0]      ovrHigh,
  input  wire logic [NCH-1:0]      ovrLow,
  output logic                     sampleTake,
  output logic                     chanALane0,
  output logic                     chanALane1,
  output logic                     chanBLane0,
  output logic                     chanBLane1,
  output logic                     chanCLane0,
  output logic                     chanCLane1,
  output logic                     chanDLane0,
  output logic                     chanDLane1,
  output logic                     serialBitClock,
  output logic                     wordFrameClock,
  output logic [1:0]               driveCurrentSel,
  output logic                     driveCurrentDouble,
  output logic [4:0]               termClkSel,
  output logic [4:0]               termDataSel,
  input  wire logic [AW-1:0]       s_axil_awaddr,
  input  wire logic                s_axil_awvalid,
  output logic                     s_axil_awready,
  input  wire logic [31:0]         s_axil_wdata,
  input  wire logic [3:0]          s_axil_wstrb,
  input  wire logic                s_axil_wvalid,
  output logic                     s_axil_wready,
  output logic [1:0]               s_axil_bresp,
  output logic                     s_axil_bvalid,
  input  wire logic                s_axil_bready,
  input  wire logic [AW-1:0]       s_axil_araddr,
  input  wire logic                s_axil_arvalid,
  output logic                     s_axil_arready,
  output logic [31:0]              s_axil_rdata,
  output logic [1:0]               s_axil_rresp,
  output logic                     s_axil_rvalid,
  input  wire logic                s_axil_rready
);
  typedef struct packed {
    logic [12:0]           ctrl;
    logic [9:0]            term;
    logic [11:0]           cust;
    tlsf_cfg_t             act;
    logic [3:0]            step;
    logic                  tog;
    logic [15:0]           smpCnt;
    logic [NCH-1:0][13:0]  held;
    logic [NCH-1:0][13:0]  seq0;
    logic [NCH-1:0][13:0]  seq1;
    logic [NCH-1:0]        out0;
    logic [NCH-1:0]        out1;
    logic                  frame;
    logic                  bclk;
    logic                  take;
    logic [2:0]            sync;
  } tlsf_st_t;

  tlsf_st_t q;
  tlsf_st_t d;

  logic                 wrEn;
  logic [AW-1:0]        wrAddr;
  logic [31:0]          wrData;
  logic [3:0]           wrStrb;
  logic                 wrOk;
  logic [AW-1:0]        rdAddr;
  logic [31:0]          rdData;
  logic                 rdOk;
  tlsf_cfg_t            cfgReg;
  logic [3:0]           half;
  logic [3:0]           lenW;
  logic                 tick;
  logic                 wrap;
  logic [3:0]           stepNext;
  logic                 wordMode;
  logic [NCH-1:0][11:0] cur;
  logic [NCH-1:0][13:0] mapA;
  logic [NCH-1:0][13:0] mapB;
  logic [NCH-1:0][13:0] map0;
  logic [NCH-1:0][13:0] map1;

  function automatic logic [11:0] fmtCode(
    input logic [11:0] raw,
    input logic        hi,
    input logic        lo,
    input tlsf_cfg_t   c,
    input logic        tog,
    input logic [11:0] cus
  );
    logic [11:0] r;
    case (c.pat)
      PAT_ZERO: r = NEG_OB; // R20
      PAT_ONE:  r = POS_OB;
      PAT_TOG:  r = tog ? TOG_B : TOG_A; // R19
      PAT_CUST: r = cus; // R21
      default:
      begin
        if (hi)
          r = c.outputCodingSel ? POS_OB : POS_TC; // R14
        else if (lo)
          r = c.outputCodingSel ? NEG_OB : NEG_TC; // R15
        else
          r = c.outputCodingSel ? raw : {~raw[11], raw[10:0]}; // R13
      end
    endcase
    return r;
  endfunction

  tlsf_axil_slave u_bus (
    .core_clk       (core_clk),
    .sys_rst        (sys_rst),
    .s_axil_awaddr  (s_axil_awaddr),
    .s_axil_awvalid (s_axil_awvalid),
    .s_axil_awready (s_axil_awready),
    .s_axil_wdata   (s_axil_wdata),
    .s_axil_wstrb   (s_axil_wstrb),
    .s_axil_wvalid  (s_axil_wvalid),
    .s_axil_wready  (s_axil_wready),
    .s_axil_bresp   (s_axil_bresp),
    .s_axil_bvalid  (s_axil_bvalid),
    .s_axil_bready  (s_axil_bready),
    .s_axil_araddr  (s_axil_araddr),
    .s_axil_arvalid (s_axil_arvalid),
    .s_axil_arready (s_axil_arready),
    .s_axil_rdata   (s_axil_rdata),
    .s_axil_rresp   (s_axil_rresp),
    .s_axil_rvalid  (s_axil_rvalid),
    .s_axil_rready  (s_axil_rready),
    .wrEn           (wrEn),
    .wrAddr         (wrAddr),
    .wrData         (wrData),
    .wrStrb         (wrStrb),
    .wrOk           (wrOk),
    .rdAddr         (rdAddr),
    .rdData         (rdData),
    .rdOk           (rdOk)
  );

  // Lane format settings written mid-word only take hold at the next word boundary,
  // so the receiver never sees a word cut between two framings.
  assign cfgReg = tlsf_cfg_t'(q.ctrl[CB_ONE:CB_PAT]);
  assign half = q.act.ser14 ? HALF14 : HALF12; // R5
  assign wordMode = q.act.oneLane || q.act.order == ORD_WORD;
  assign lenW = wordMode ? {half[2:0], 1'b0} : half; // R1
  assign tick = (q.sync[1] && !q.sync[2]) ||
                (!q.sync[1] && q.sync[2] && (!q.act.sdr || q.act.oneLane)); // R2
  assign wrap = q.step == lenW - 4'h1;
  assign stepNext = wrap ? 4'h0 : q.step + 4'h1;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_chan
      assign cur[gi] = fmtCode(chanCode[gi], ovrHigh[gi], ovrLow[gi], cfgReg, q.tog, q.cust); // R25
      assign mapA[gi] = (cfgReg.order == ORD_WORD && !cfgReg.oneLane) ?
                        q.held[gi] : {2'b00, cur[gi]}; // R4
      assign mapB[gi] = {2'b00, cur[gi]};
      tlsf_lane_map u_map (
        .wordA (mapA[gi]),
        .wordB (mapB[gi]),
        .cfg   (cfgReg), // R3
        .seq0  (map0[gi]),
        .seq1  (map1[gi])
      );
    end
  endgenerate

  always_comb
  begin
    wrOk = wrAddr == ADDR_CTRL || wrAddr == ADDR_TERM ||
           wrAddr == ADDR_CUSLO || wrAddr == ADDR_CUSHI;
    rdOk = 1'b1;
    case (rdAddr)
      ADDR_CTRL:  rdData = {19'h00000, q.ctrl};
      ADDR_TERM:  rdData = {19'h00000, q.term[9:5], 3'h0, q.term[4:0]};
      ADDR_CUSLO: rdData = {24'h000000, q.cust[7:0]};
      ADDR_CUSHI: rdData = {28'h0000000, q.cust[11:8]};
      ADDR_STAT:  rdData = {12'h000, q.step, q.smpCnt};
      default:
      begin
        rdData = 32'h00000000;
        rdOk = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    d = q;
    d.take = 1'b0;
    d.sync = {q.sync[1:0], bitClkPin};
    d.bclk = q.sync[1];
    if (wrEn)
    begin
      case (wrAddr)
        ADDR_CTRL:
        begin
          if (wrStrb[0])
            d.ctrl[7:0] = wrData[7:0];
          if (wrStrb[1])
            d.ctrl[12:8] = wrData[12:8]; // R16
        end
        ADDR_TERM:
        begin
          if (wrStrb[0])
            d.term[4:0] = wrData[TB_CLK+:5]; // R17
          if (wrStrb[1])
            d.term[9:5] = wrData[TB_DATA+:5];
        end
        ADDR_CUSLO:
        begin
          if (wrStrb[0])
            d.cust[7:0] = wrData[7:0]; // R21
        end
        ADDR_CUSHI:
        begin
          if (wrStrb[0])
            d.cust[11:8] = wrData[3:0];
        end
        default:
        begin
          d.cust = q.cust;
        end
      endcase
    end
    if (tick)
    begin
      d.step = stepNext;
      d.frame = stepNext < {1'b0, lenW[3:1]}; // R6 R10
      if (q.act.order == ORD_WORD && !q.act.oneLane && stepNext == half)
      begin
        for (int i = 0; i < NCH; i++)
          d.held[i] = {2'b00, cur[i]}; // R9
        d.tog = ~q.tog;
        d.take = 1'b1;
      end
      if (wrap)
      begin
        d.act = cfgReg;
        d.seq0 = map0;
        d.seq1 = map1;
        for (int i = 0; i < NCH; i++)
        begin
          d.out0[i] = map0[i][0]; // R24
          d.out1[i] = map1[i][0];
        end
        d.tog = ~q.tog; // R19
        d.smpCnt = q.smpCnt + 16'h0001;
        d.take = 1'b1;
      end
      else
      begin
        for (int i = 0; i < NCH; i++)
        begin
          d.out0[i] = q.seq0[i][stepNext];
          d.out1[i] = q.seq1[i][stepNext];
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.term <= TERM_RST;
      q.cust <= CUST_RST;
      q.frame <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign sampleTake = q.take;
  assign {chanDLane0, chanCLane0, chanBLane0, chanALane0} = q.out0;
  assign {chanDLane1, chanCLane1, chanBLane1, chanALane1} = q.out1;
  assign serialBitClock = q.bclk;
  assign wordFrameClock = q.frame;
  assign driveCurrentSel = q.ctrl[CB_CUR+:2]; // R16
  assign driveCurrentDouble = q.ctrl[CB_DBL];
  assign termClkSel = q.term[4:0];
  assign termDataSel = q.term[9:5];

  a_step_range: assert property (@(posedge core_clk) disable iff (sys_rst) // R1
    q.step < lenW) else $error("bit step beyond word length");
  a_frame_rise: assert property (@(posedge core_clk) disable iff (sys_rst) // R10
    $rose(q.frame) |-> q.step == 4'h0 && $past(wrap)) else $error("frame rose mid word");
  a_clamp_pos: assert property (@(posedge core_clk) disable iff (sys_rst) // R14
    (cfgReg.pat == PAT_NORM && ovrHigh[0]) |->
    cur[0] == (cfgReg.outputCodingSel ? POS_OB : POS_TC)) else $error("bad positive clamp");
  a_clamp_neg: assert property (@(posedge core_clk) disable iff (sys_rst) // R15
    (cfgReg.pat == PAT_NORM && ovrLow[1] && !ovrHigh[1]) |->
    cur[1] == (cfgReg.outputCodingSel ? NEG_OB : NEG_TC)) else $error("bad negative clamp");
  a_reset_msb: assert property (@(posedge core_clk) // R11
    $past(sys_rst) |-> !cfgReg.lsbFirst) else $error("LSB first after reset");
  a_reset_coding: assert property (@(posedge core_clk) // R13
    $past(sys_rst) |-> !cfgReg.outputCodingSel) else $error("offset binary after reset");
  a_pat_common: assert property (@(posedge core_clk) disable iff (sys_rst) // R20
    (cfgReg.pat inside {PAT_ZERO, PAT_ONE, PAT_TOG, PAT_CUST, PAT_SYNC, PAT_DESK}) |->
    (cfgReg.pat inside {PAT_SYNC, PAT_DESK} ? map0[0] == map0[3] && map1[0] == map1[3] :
     cur[0] == cur[1] && cur[1] == cur[2] && cur[2] == cur[3]))
    else $error("channels differ under test pattern");
  a_pad_zero: assert property (@(posedge core_clk) disable iff (sys_rst) // R4
    (q.act.ser14 && q.act.order == ORD_BYTE && !q.act.oneLane && !q.act.lsbFirst &&
     q.act.pat != PAT_SYNC && q.act.pat != PAT_DESK && q.step < 4'h2 && !$past(sys_rst))
    |-> q.out1 == 4'h0) else $error("pad bits not zero");
  a_deskew_alt: assert property (@(posedge core_clk) disable iff (sys_rst) // R18
    (q.act.pat == PAT_DESK) |-> q.out0[2] == ~q.step[0]) else $error("deskew not alternating");
  a_word_take: assert property (@(posedge core_clk) disable iff (sys_rst) // R9
    (tick && q.act.order == ORD_WORD && !q.act.oneLane && stepNext == half) |=> q.take)
    else $error("second word-wise sample missed");
  c_word_wrap: cover property (@(posedge core_clk) tick && wrap && q.act.order == ORD_WORD);
  c_sdr14_wrap: cover property (@(posedge core_clk) tick && wrap && q.act.ser14 && q.act.sdr);
  c_sync_wrap: cover property (@(posedge core_clk) tick && wrap && q.act.pat == PAT_SYNC);
endmodule

// ===== sim/tlsf_rx_model.sv
module tlsf_rx_model
  import tlsf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        sdr,
  input  wire logic        serialBitClock,
  input  wire logic        wordFrameClock,
  input  wire logic [7:0]  lanes,
  output logic [7:0][13:0] word,
  output logic [4:0]       bitCount,
  output int               frames
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0][13:0] shift_q;
  logic [4:0]       cnt_q;
  logic             bck_q;
  logic             fr_q;
  logic             e1_q;
  logic             e2_q;
  // Bits are taken three cycles after a clock edge, near mid-bit, so that
  // the lane flops have settled whichever side of the edge they switch on.
  always_ff @(posedge core_clk)
  begin
    bck_q <= serialBitClock;
    e1_q  <= (serialBitClock != bck_q) && (!sdr || serialBitClock);
    e2_q  <= e1_q;
    fr_q  <= wordFrameClock;
    if (e2_q)
    begin
      for (int i = 0; i < 8; i++)
        shift_q[i] <= {shift_q[i][12:0], lanes[i]};
    end
    if (sys_rst)
    begin
      cnt_q  <= 5'h00;
      frames <= 0;
    end
    else if (wordFrameClock && !fr_q)
    begin
      word     <= shift_q;
      bitCount <= cnt_q;
      cnt_q    <= {4'h0, e2_q};
      frames   <= frames + 1;
    end
    else if (e2_q)
      cnt_q <= cnt_q + 5'h01;
  end
endmodule

// ===== sim/tb.sv
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin numErrors++; $display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end
module tb
  import tlsf_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [12:0] ctrl;
    logic [1:0]  ovr;
    logic [13:0] l0;
    logic [13:0] l1;
    logic [4:0]  n;
  } tlsf_row_t;
  logic                 core_clk;
  logic                 sys_rst;
  logic                 bitClkPin;
  logic                 sdr;
  logic [NCH-1:0][11:0] chanCode;
  logic [NCH-1:0]       ovrHigh;
  logic [NCH-1:0]       ovrLow;
  logic [7:0]           lanes;
  logic                 serialBitClock;
  logic                 wordFrameClock;
  logic [1:0]           driveCurrentSel;
  logic                 driveCurrentDouble;
  logic [4:0]           termClkSel;
  logic [4:0]           termDataSel;
  logic [AW-1:0]        s_axil_awaddr;
  logic                 s_axil_awvalid;
  logic                 s_axil_awready;
  logic [31:0]          s_axil_wdata;
  logic [3:0]           s_axil_wstrb;
  logic                 s_axil_wvalid;
  logic                 s_axil_wready;
  logic [1:0]           s_axil_bresp;
  logic                 s_axil_bvalid;
  logic                 s_axil_bready;
  logic [AW-1:0]        s_axil_araddr;
  logic                 s_axil_arvalid;
  logic                 s_axil_arready;
  logic [31:0]          s_axil_rdata;
  logic [1:0]           s_axil_rresp;
  logic                 s_axil_rvalid;
  logic                 s_axil_rready;
  logic [7:0][13:0]     word;
  logic [4:0]           bitCount;
  logic [1:0]           wResp;
  logic [1:0]           rResp;
  logic [31:0]          rData;
  logic [13:0]          prevWord;
  int                   frames;
  int                   numErrors;
  int                   nChecks;
  int                   takes;
  logic                 sampleTake;
  // Input code 0xA5C on every channel in normal-pattern rows; lane words read first bit highest.
  tlsf_row_t rows [17] = '{
    '{13'h000, 2'h0, 14'h01C, 14'h009, 5'h06},
    '{13'h008, 2'h0, 14'h01C, 14'h029, 5'h06},
    '{13'h010, 2'h0, 14'h00E, 14'h024, 5'h06},
    '{13'h020, 2'h0, 14'h00E, 14'h012, 5'h06},
    '{13'h100, 2'h0, 14'h05C, 14'h004, 5'h07},
    '{13'h040, 2'h0, 14'h25C, 14'h25C, 5'h0C},
    '{13'h080, 2'h0, 14'h01C, 14'h009, 5'h06},
    '{13'h180, 2'h0, 14'h05C, 14'h004, 5'h07},
    '{13'h200, 2'h0, 14'h25C, 14'h000, 5'h0C},
    '{13'h000, 2'h2, 14'h03F, 14'h01F, 5'h06},
    '{13'h008, 2'h2, 14'h03F, 14'h03F, 5'h06},
    '{13'h000, 2'h1, 14'h000, 14'h020, 5'h06},
    '{13'h008, 2'h1, 14'h000, 14'h000, 5'h06},
    '{13'h001, 2'h0, 14'h000, 14'h000, 5'h06},
    '{13'h002, 2'h0, 14'h03F, 14'h03F, 5'h06},
    '{13'h004, 2'h0, 14'h005, 14'h00F, 5'h06},
    '{13'h105, 2'h0, 14'h078, 14'h078, 5'h07}
  };
  tlsf_formatter uut (
    .core_clk, .sys_rst, .bitClkPin, .chanCode, .ovrHigh, .ovrLow, .sampleTake,
    .chanALane0(lanes[0]), .chanALane1(lanes[1]), .chanBLane0(lanes[2]),
    .chanBLane1(lanes[3]), .chanCLane0(lanes[4]), .chanCLane1(lanes[5]),
    .chanDLane0(lanes[6]), .chanDLane1(lanes[7]), .serialBitClock, .wordFrameClock,
    .driveCurrentSel, .driveCurrentDouble, .termClkSel, .termDataSel,
    .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
    .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
    .s_axil_rvalid, .s_axil_rready
  );
  tlsf_rx_model rx (
    .core_clk, .sys_rst, .sdr, .serialBitClock, .wordFrameClock, .lanes, .word,
    .bitCount, .frames
  );
  always_ff @(posedge core_clk)
  begin
    if (sampleTake)
      takes <= takes + 1;
  end
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  // The bit clock runs free with its own phase, as a PLL output would.
  initial
  begin
    bitClkPin = 1'h0;
    #3;
    forever #40 bitClkPin = ~bitClkPin;
  end
  task automatic stopTest();
    if (numErrors == 0 && nChecks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic axiWrite(input logic [AW-1:0] a, input logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge core_clk);
    s_axil_awaddr  <= a;
    s_axil_wdata   <= d;
    s_axil_awvalid <= 1'h1;
    s_axil_wvalid  <= 1'h1;
    s_axil_bready  <= 1'h1;
    while (!done)
    begin
      @(posedge core_clk);
      if (s_axil_awvalid && s_axil_awready)
        s_axil_awvalid <= 1'h0;
      if (s_axil_wvalid && s_axil_wready)
        s_axil_wvalid <= 1'h0;
      if (s_axil_bvalid === 1'h1)
      begin
        done = 1'b1;
        wResp = s_axil_bresp;
        s_axil_bready <= 1'h0;
      end
    end
  endtask
  task automatic axiRead(input logic [AW-1:0] a);
    bit done;
    done = 1'b0;
    @(posedge core_clk);
    s_axil_araddr  <= a;
    s_axil_arvalid <= 1'h1;
    s_axil_rready  <= 1'h1;
    while (!done)
    begin
      @(posedge core_clk);
      if (s_axil_arvalid && s_axil_arready)
        s_axil_arvalid <= 1'h0;
      if (s_axil_rvalid === 1'h1)
      begin
        done = 1'b1;
        rData = s_axil_rdata;
        rResp = s_axil_rresp;
        s_axil_rready <= 1'h0;
      end
    end
  endtask
  task automatic waitFrames(input int k);
    int f0;
    f0 = frames;
    while (frames < f0 + k)
      @(posedge core_clk);
  endtask
  // New settings take hold only at a word boundary, so a few frames pass first.
  task automatic checkRow(input tlsf_row_t r);
    logic [13:0] m;
    int t0;
    ovrHigh <= {NCH{r.ovr[1]}};
    ovrLow  <= {NCH{r.ovr[0]}};
    sdr     <= r.ctrl[7];
    // Distinct channel codes show that a pattern really replaces the samples.
    chanCode <= (r.ctrl[2:0] != 3'h0) ? {12'h123, 12'h456, 12'h789, 12'hA5C} :
                {NCH{12'hA5C}};
    axiWrite(ADDR_CTRL, {19'h0, r.ctrl});
    waitFrames(3);
    t0 = takes;
    waitFrames(1);
    m = (14'h1 << r.n) - 14'h1;
    `CHK("lane0", r.l0, word[0] & m)
    `CHK("lane1", r.l1, word[1] & m)
    `CHK("bitsPerFrame", r.n, bitCount)
    `CHK("takesPerFrame", (r.ctrl[6:5] == 2'h2 && !r.ctrl[9]) ? 2 : 1, takes - t0)
    for (int c = 1; c < NCH; c++)
    begin
      `CHK("chanLane0", word[0], word[2*c])
      `CHK("chanLane1", word[1], word[2*c+1])
    end
  endtask
  initial
  begin
    #200us;
    numErrors++;
    stopTest();
  end
  initial
  begin
    numErrors = 0;
    nChecks = 0;
    sys_rst = 1'h1;
    sdr = 1'h0;
    chanCode = {NCH{12'hA5C}};
    ovrHigh = '0;
    ovrLow = '0;
    s_axil_awaddr = '0;
    s_axil_awvalid = 1'h0;
    s_axil_wdata = '0;
    s_axil_wstrb = 4'hF;
    s_axil_wvalid = 1'h0;
    s_axil_bready = 1'h0;
    s_axil_araddr = '0;
    s_axil_arvalid = 1'h0;
    s_axil_rready = 1'h0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'h0;
    axiWrite(ADDR_CUSLO, 32'h000000C5);
    axiWrite(ADDR_CUSHI, 32'h00000003);
    foreach (rows[i])
      checkRow(rows[i]);
    axiWrite(ADDR_CTRL, 32'h00001C00);
    `CHK("curSel", 2'h3, driveCurrentSel)
    `CHK("curDbl", 1'h1, driveCurrentDouble)
    axiRead(ADDR_CTRL);
    `CHK("ctrlRead", 32'h00001C00, rData)
    axiWrite(ADDR_TERM, 32'h00001115);
    `CHK("termClk", 5'h15, termClkSel)
    `CHK("termData", 5'h11, termDataSel)
    axiWrite(ADDR_STAT, 32'h00000001);
    `CHK("statWrResp", RESP_ERR, wResp)
    axiRead(8'h20);
    `CHK("unmappedResp", RESP_ERR, rResp)
    axiWrite(ADDR_CTRL, 32'h00000003);
    waitFrames(4);
    prevWord = word[0];
    waitFrames(1);
    `CHK("toggle", 14'h03F, (prevWord ^ word[0]) & 14'h03F)
    axiWrite(ADDR_CTRL, 32'h00000043);
    waitFrames(4);
    `CHK("wordToggle", 14'hFFF, (word[0] ^ word[1]) & 14'hFFF)
    axiWrite(ADDR_CTRL, 32'h00000006);
    waitFrames(4);
    `CHK("deskew0", 14'h01F, (word[0] ^ (word[0] >> 1)) & 14'h01F)
    `CHK("deskew1", 14'h01F, (word[1] ^ (word[1] >> 1)) & 14'h01F)
    // A second reset mid-run must bring back the default coding and order.
    @(posedge core_clk);
    sys_rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("lanesRst", 8'h00, lanes)
    `CHK("frameRst", 1'h1, wordFrameClock)
    @(posedge core_clk);
    sys_rst <= 1'h0;
    axiRead(ADDR_CTRL);
    `CHK("ctrlRst", 32'h00000000, rData)
    `CHK("curRst", 2'h0, driveCurrentSel)
    checkRow(rows[0]);
    stopTest();
  end
endmodule
